// [core/ppaf_pkg.sv]
package ppaf_pkg;
    localparam int PORT_W        = 8;
    localparam int SYNC_STAGES   = 2;
    // Reset needs two machine cycles of twelve oscillator periods each.
    localparam int OSC_PER_MC    = 12;
    localparam int RESET_MC      = 2;
    localparam int RESET_CYCLES  = OSC_PER_MC * RESET_MC;
    localparam int SYS_CLOCK_OUT_DIV    = 12;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    // Pin positions on the control_alt_port.
    localparam int CA_RX  = 0;
    localparam int CA_TX  = 1;
    localparam int CA_IRA = 2;
    localparam int CA_IRB = 3;
    localparam int CA_CA  = 4;
    localparam int CA_CB  = 5;
    localparam int CA_WR  = 6;
    localparam int CA_RD  = 7;
    // Pin positions on the timer_alt_port.
    localparam int TA_IRC = 4;
    localparam int TA_RLD = 5;
    localparam int TA_CLK = 6;
    localparam int TA_CC  = 7;
    typedef enum logic [1:0] {PPAF_BUS_PORT, PPAF_BUS_WIDE,
                              PPAF_BUS_NARROW, PPAF_BUS_FETCH} ppaf_bus_t;
endpackage

// [core/ppaf_ports.sv]
// Summary of operation
// - Power saving only while power_save_allow low.
// - Reset after reset pin low two machine cycles.
// - Eight-bit ports; latch one means weak pull-up.
// - Analog input port is input only.
// - Pins 0,1 carry serial receive and transmit.
// - Pins 2-5 carry interrupts and counter inputs.
// - Pins 6,7 carry external write, read strobes.
// - Timer pins 0-3 interrupt, compare, capture.
// - Timer pins 4-7: irq, reload, clock, counter.
// - Verify mode takes low address from timer port.
// - Oscillator input divided by two first.
// - High port drives address byte, strong ones.
// - Narrow moves keep high port latch value.
// - Clock output is clk divided by twelve.
`timescale 1ns/1ps
`default_nettype none
module ppaf_ports
    import ppaf_pkg::*;
#(
    parameter int W = PORT_W
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         osc_drive_in,
    input  wire logic         reset_pin_n,
    input  wire logic         power_save_allow,
    input  wire logic         idle_req,
    input  wire logic         pdown_req,
    input  wire logic         latch_we,
    input  wire logic [2:0]   latch_sel,
    input  wire logic [W-1:0] latch_wdata,
    input  wire logic [W-1:0] timer_alt_in,
    input  wire logic [W-1:0] high_address_in,
    input  wire logic [W-1:0] control_alt_in,
    input  wire logic [W-1:0] plain_io_in,
    input  wire logic [W-1:0] aux_io_in,
    input  wire logic [W-1:0] analog_input_port,
    input  wire logic [1:0]   bus_mode,
    input  wire logic [W-1:0] addr_high,
    input  wire logic         serial_sync_mode,
    input  wire logic         serial_tx_bit,
    input  wire logic         serial_rx_drive,
    input  wire logic         ext_write_strobe_n,
    input  wire logic         ext_read_strobe_n,
    input  wire logic [3:0]   compare_en,
    input  wire logic [3:0]   compare_val,
    input  wire logic         sys_clock_out_en,
    input  wire logic         verify_mode,
    output logic [W-1:0]      timer_alt_out,
    output logic [W-1:0]      timer_alt_oe,
    output logic [W-1:0]      high_address_out,
    output logic [W-1:0]      high_address_oe,
    output logic [W-1:0]      control_alt_out,
    output logic [W-1:0]      control_alt_oe,
    output logic [W-1:0]      plain_io_out,
    output logic [W-1:0]      plain_io_oe,
    output logic [W-1:0]      aux_io_out,
    output logic [W-1:0]      aux_io_oe,
    output logic [W-1:0]      timer_alt_rd_q,
    output logic [W-1:0]      high_address_rd_q,
    output logic [W-1:0]      control_alt_rd_q,
    output logic [W-1:0]      plain_io_rd_q,
    output logic [W-1:0]      aux_io_rd_q,
    output logic [W-1:0]      analog_digital_q,
    output logic [W-1:0]      analog_mux_q,
    output logic              serial_rx_line_q,
    output logic              ext_irq_a_q,
    output logic              ext_irq_b_q,
    output logic              ext_irq_c_q,
    output logic [3:0]        irq_capcomp_q,
    output logic              count_in_a_q,
    output logic              count_in_b_q,
    output logic              count_in_c_q,
    output logic              reload_trigger_in_q,
    output logic [W-1:0]      verify_addr_q,
    output logic              idle_q,
    output logic              pdown_q,
    output logic              chip_reset_q,
    output logic              osc_half_q
);
    localparam int NP = 5;
    localparam int RCW = $clog2(RESET_CYCLES + 1);
    localparam int CKW = $clog2(SYS_CLOCK_OUT_DIV);

    logic [W-1:0] latch_q [NP];
    logic [W-1:0] s1_q [NP+1];
    logic [W-1:0] s2_q [NP+1];
    logic [W-1:0] pin_in [NP+1];
    logic         rst_s1_q, rst_s2_q, ps_s1_q, ps_s2_q;
    logic [RCW-1:0] rst_cnt_q;
    logic [CKW-1:0] ck_cnt_q;
    logic         clk_div_q, osc_prev_q;
    logic [W-1:0] ta_d, ta_oe_d, ca_d, ca_oe_d, ha_d, ha_oe_d;

    // Quasi-bidirectional pin: a zero drives strong, a one only pulls weakly.
    function automatic logic [W-1:0] quasi_oe(input logic [W-1:0] v);
        return ~v;
    endfunction

    assign pin_in[0] = timer_alt_in;
    assign pin_in[1] = high_address_in;
    assign pin_in[2] = control_alt_in;
    assign pin_in[3] = plain_io_in;
    assign pin_in[4] = aux_io_in;
    assign pin_in[5] = analog_input_port;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NP; i++) latch_q[i] <= PORT_RESET;
        end else if (latch_we && latch_sel < 3'(NP)) begin
            latch_q[latch_sel] <= latch_wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i <= NP; i++) begin
                s1_q[i] <= '0;
                s2_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i <= NP; i++) begin
                s1_q[i] <= pin_in[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_alt_rd_q      <= '0;
            high_address_rd_q   <= '0;
            control_alt_rd_q    <= '0;
            plain_io_rd_q       <= '0;
            aux_io_rd_q         <= '0;
            analog_digital_q    <= '0;
            analog_mux_q        <= '0;
            serial_rx_line_q    <= 1'b0;
            ext_irq_a_q         <= 1'b0;
            ext_irq_b_q         <= 1'b0;
            ext_irq_c_q         <= 1'b0;
            irq_capcomp_q       <= '0;
            count_in_a_q        <= 1'b0;
            count_in_b_q        <= 1'b0;
            count_in_c_q        <= 1'b0;
            reload_trigger_in_q <= 1'b0;
            verify_addr_q       <= '0;
        end else begin
            timer_alt_rd_q      <= s2_q[0];
            high_address_rd_q   <= s2_q[1];
            control_alt_rd_q    <= s2_q[2];
            plain_io_rd_q       <= s2_q[3];
            aux_io_rd_q         <= s2_q[4];
            analog_digital_q    <= s2_q[5];
            analog_mux_q        <= s2_q[5];
            // A latch at zero holds the pin low, so inputs see zero.
            serial_rx_line_q    <= s2_q[2][CA_RX];
            ext_irq_a_q         <= s2_q[2][CA_IRA];
            ext_irq_b_q         <= s2_q[2][CA_IRB];
            count_in_a_q        <= s2_q[2][CA_CA];
            count_in_b_q        <= s2_q[2][CA_CB];
            irq_capcomp_q       <= s2_q[0][3:0];
            ext_irq_c_q         <= s2_q[0][TA_IRC];
            reload_trigger_in_q <= s2_q[0][TA_RLD];
            count_in_c_q        <= s2_q[0][TA_CC];
            if (verify_mode) begin
                verify_addr_q <= s2_q[0];
            end
        end
    end

    // Control port pins: latch AND secondary function; timer and high port functions replace the latch.
    always_comb begin
        ca_d = latch_q[2];
        ca_d[CA_RX] = latch_q[2][CA_RX] & (~serial_sync_mode
                      | serial_rx_drive);
        ca_d[CA_TX] = latch_q[2][CA_TX] & serial_tx_bit;
        ca_d[CA_WR] = latch_q[2][CA_WR] & ext_write_strobe_n;
        ca_d[CA_RD] = latch_q[2][CA_RD] & ext_read_strobe_n;
        ca_oe_d = quasi_oe(ca_d);
        ta_d = latch_q[0];
        ta_oe_d = quasi_oe(latch_q[0]);
        for (int i = 0; i < 4; i++) begin
            if (compare_en[i]) begin
                ta_d[i] = compare_val[i];
                ta_oe_d[i] = 1'b1;
            end
        end
        if (sys_clock_out_en) begin
            ta_d[TA_CLK] = clk_div_q;
            ta_oe_d[TA_CLK] = 1'b1;
        end
        ha_d = latch_q[1];
        ha_oe_d = quasi_oe(latch_q[1]);
        if (bus_mode == PPAF_BUS_WIDE || bus_mode == PPAF_BUS_FETCH) begin
            ha_d = addr_high;
            ha_oe_d = '1;
        end // Narrow moves fall through to the latch.
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_alt_out    <= PORT_RESET;
            timer_alt_oe     <= '0;
            high_address_out <= PORT_RESET;
            high_address_oe  <= '0;
            control_alt_out  <= PORT_RESET;
            control_alt_oe   <= '0;
            plain_io_out     <= PORT_RESET;
            plain_io_oe      <= '0;
            aux_io_out       <= PORT_RESET;
            aux_io_oe        <= '0;
        end else begin
            timer_alt_out    <= ta_d;
            timer_alt_oe     <= ta_oe_d;
            high_address_out <= ha_d;
            high_address_oe  <= ha_oe_d;
            control_alt_out  <= ca_d;
            control_alt_oe   <= ca_oe_d;
            plain_io_out     <= latch_q[3];
            plain_io_oe      <= quasi_oe(latch_q[3]);
            aux_io_out       <= latch_q[4];
            aux_io_oe        <= quasi_oe(latch_q[4]);
        end
    end

    // Only rising oscillator edges toggle, so a long high phase counts once.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_prev_q <= 1'b1;
            osc_half_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_drive_in;
            if (osc_drive_in && !osc_prev_q) begin
                osc_half_q <= ~osc_half_q;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ck_cnt_q  <= '0;
            clk_div_q <= 1'b0;
        end else if (ck_cnt_q == CKW'(SYS_CLOCK_OUT_DIV / 2 - 1)) begin
            ck_cnt_q  <= '0;
            clk_div_q <= ~clk_div_q;
        end else begin
            ck_cnt_q  <= ck_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_s1_q     <= 1'b1;
            rst_s2_q     <= 1'b1;
            rst_cnt_q    <= '0;
            chip_reset_q <= 1'b0;
        end else begin
            rst_s1_q <= reset_pin_n;
            rst_s2_q <= rst_s1_q;
            if (rst_s2_q) begin
                rst_cnt_q    <= '0;
                chip_reset_q <= 1'b0;
            end else if (rst_cnt_q == RCW'(RESET_CYCLES - 1)) begin
                chip_reset_q <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ps_s1_q <= 1'b1;
            ps_s2_q <= 1'b1;
            idle_q  <= 1'b0;
            pdown_q <= 1'b0;
        end else begin
            ps_s1_q <= power_save_allow;
            ps_s2_q <= ps_s1_q;
            if (chip_reset_q) begin
                idle_q  <= 1'b0;
                pdown_q <= 1'b0;
            end else if (!ps_s2_q) begin
                if (pdown_req) pdown_q <= 1'b1;
                if (idle_req)  idle_q  <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [test/ppaf_board.sv]
`timescale 1ns/1ps
`default_nettype none
module ppaf_board (
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] drv_en,
    input  wire logic [7:0] drv_val,
    output wire logic [7:0] pin
);
    // A released line rises on its pull-up; it never keeps old data.
    assign pin = oe & out | ~oe & (drv_en & drv_val | ~drv_en);
endmodule
`default_nettype wire

// [test/ppaf_ports_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ppaf_ports_assertions
    import ppaf_pkg::*;
#(
    parameter int W = PORT_W
) (
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         reset_pin_n,
    input wire logic         power_save_allow,
    input wire logic         osc_drive_in,
    input wire logic         osc_half_q,
    input wire logic [1:0]   bus_mode,
    input wire logic [W-1:0] addr_high,
    input wire logic         sys_clock_out_en,
    input wire logic         verify_mode,
    input wire logic [W-1:0] timer_alt_in,
    input wire logic [W-1:0] analog_input_port,
    input wire logic [W-1:0] high_address_out,
    input wire logic [W-1:0] high_address_oe,
    input wire logic [W-1:0] timer_alt_out,
    input wire logic [W-1:0] analog_digital_q,
    input wire logic [3:0]   irq_capcomp_q,
    input wire logic [W-1:0] verify_addr_q,
    input wire logic         idle_q,
    input wire logic         pdown_q,
    input wire logic         chip_reset_q
);
    logic [2:0] age_q;
    logic [5:0] low_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) age_q <= '0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    // Counts raw pin-low cycles so the reset filter can be held to 24.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) low_q <= '0;
        else if (reset_pin_n) low_q <= '0;
        else if (low_q != 6'h3F) low_q <= low_q + 6'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_hp_bus;
        bus_mode[0] |=> high_address_oe == '1
            && high_address_out == $past(addr_high);
    endproperty
    property p_idle_block;
        power_save_allow [*4] ##0 !idle_q |=> !idle_q;
    endproperty
    property p_pdown_block;
        power_save_allow [*4] ##0 !pdown_q |=> !pdown_q;
    endproperty
    property p_reset_min;
        $rose(chip_reset_q) |-> low_q >= RESET_CYCLES;
    endproperty
    property p_osc_hold;
        !osc_drive_in [*4] |=> $stable(osc_half_q);
    endproperty
    property p_osc_rise;
        age_q != 3'h0 && $rose(osc_drive_in) |=>
            osc_half_q != $past(osc_half_q);
    endproperty
    property p_osc_level;
        age_q != 3'h0 && osc_drive_in && $past(osc_drive_in) |=>
            $stable(osc_half_q);
    endproperty
    property p_clk_div;
        sys_clock_out_en [*8] ##1 sys_clock_out_en [*8] |->
            timer_alt_out[TA_CLK] != $past(timer_alt_out[TA_CLK], 6);
    endproperty
    property p_analog;
        age_q == 3'h7 |-> analog_digital_q == $past(analog_input_port, 3);
    endproperty
    property p_capcomp;
        age_q == 3'h7 |-> irq_capcomp_q == $past(timer_alt_in[3:0], 3);
    endproperty
    property p_verify_hold;
        !verify_mode [*4] |=> $stable(verify_addr_q);
    endproperty
    a_hp_bus: assert property (p_hp_bus)
        else $error("high port not carrying address");
    a_idle_block: assert property (p_idle_block)
        else $error("idle entered while power save barred");
    a_pdown_block: assert property (p_pdown_block)
        else $error("power-down entered while barred");
    a_reset_min: assert property (p_reset_min)
        else $error("chip reset after too short a pulse");
    a_osc_hold: assert property (p_osc_hold)
        else $error("divider moved without oscillator high");
    a_osc_rise: assert property (p_osc_rise)
        else $error("divider missed an oscillator rise");
    a_osc_level: assert property (p_osc_level)
        else $error("divider toggled on a steady high level");
    a_clk_div: assert property (p_clk_div)
        else $error("clock output half period not six");
    a_analog: assert property (p_analog)
        else $error("analog digital read wrong");
    a_capcomp: assert property (p_capcomp)
        else $error("capture inputs wrong");
    a_verify_hold: assert property (p_verify_hold)
        else $error("verify address moved outside verify");
    c_reset: cover property ($rose(chip_reset_q));
    c_idle: cover property ($rose(idle_q));
    c_wide: cover property (bus_mode == PPAF_BUS_WIDE);
endmodule
bind ppaf_ports ppaf_ports_assertions #(.W(W)) ppaf_ports_assertions_inst (
    .clk, .reset, .reset_pin_n, .power_save_allow, .osc_drive_in,
    .bus_mode, .addr_high, .sys_clock_out_en, .verify_mode, .timer_alt_in,
    .analog_input_port, .high_address_out, .high_address_oe,
    .timer_alt_out, .analog_digital_q, .irq_capcomp_q, .verify_addr_q,
    .idle_q, .pdown_q, .chip_reset_q, .osc_half_q);
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    import ppaf_pkg::*;
    logic clk = 0, reset = 1, osc_drive_in = 0, reset_pin_n = 1;
    logic power_save_allow = 1, idle_req = 0, pdown_req = 0, latch_we = 0;
    logic [2:0] latch_sel = 0;
    logic [7:0] latch_wdata = 0, analog_input_port = 0, addr_high = 0;
    logic [1:0] bus_mode = 0;
    logic serial_sync_mode = 0, serial_tx_bit = 1, serial_rx_drive = 0;
    logic ext_write_strobe_n = 1, ext_read_strobe_n = 1, sys_clock_out_en = 0;
    logic [3:0] compare_en = 0, compare_val = 0, irq_capcomp_q;
    logic verify_mode = 0, t;
    logic [39:0] drv_en = 0, drv_val = 0;
    wire [39:0] pins;
    wire [7:0] timer_alt_in, high_address_in, control_alt_in, plain_io_in;
    wire [7:0] aux_io_in;
    logic [7:0] timer_alt_out, timer_alt_oe, high_address_out, high_address_oe,
        control_alt_out, control_alt_oe, plain_io_out, plain_io_oe, aux_io_out,
        aux_io_oe, timer_alt_rd_q, high_address_rd_q, control_alt_rd_q,
        plain_io_rd_q, aux_io_rd_q, analog_digital_q, analog_mux_q,
        verify_addr_q, v, p, hv, av;
    logic serial_rx_line_q, ext_irq_a_q, ext_irq_b_q, ext_irq_c_q, idle_q,
        count_in_a_q, count_in_b_q, count_in_c_q, reload_trigger_in_q,
        pdown_q, chip_reset_q, osc_half_q;
    logic [15:0] o;
    logic [2:0] sl [3] = '{3'h1, 3'h3, 3'h4};
    int err_total = 0, n_compared = 0, n;
    ppaf_ports ppaf_ports_inst (.*);
    ppaf_board ppaf_board_inst [4:0] (.out({aux_io_out, plain_io_out,
        control_alt_out, high_address_out, timer_alt_out}), .oe({aux_io_oe,
        plain_io_oe, control_alt_oe, high_address_oe, timer_alt_oe}),
        .drv_en, .drv_val, .pin(pins));
    assign {aux_io_in, plain_io_in, control_alt_in, high_address_in,
        timer_alt_in} = pins;
    initial forever #10 clk = ~clk;
    always @(posedge clk) osc_drive_in <= #1 1'($urandom);
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        latch_we = 1; latch_sel = s; latch_wdata = d; step(1); latch_we = 0;
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, compared %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(38688));
        step(16); reset = 0; step(2);
        `CHK({plain_io_out, aux_io_out, plain_io_oe}, 24'hFFFF00)
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            wr(sl[k % 3], v); step(2);
            if (k == 3) hv = v;
            if (k == 4) p = v;
            if (k == 5) av = v;
            o = (k % 3 == 0) ? {high_address_out, high_address_oe} :
                (k % 3 == 1) ? {plain_io_out, plain_io_oe} :
                {aux_io_out, aux_io_oe};
            `CHK(o, {v, ~v})
        end
        wr(3'h5, ~p); step(2); `CHK(plain_io_out, p)
        wr(3'h3, 8'hFF); step(2);
        verify_mode = 1; drv_en = 40'h00_FF_3D_00_BF;
        for (int k = 0; k < 6; k++) begin
            drv_val = k ? 40'({$urandom, $urandom}) : '0;
            analog_input_port = 8'($urandom); step(3);
            `CHK(plain_io_rd_q, drv_val[31:24])
            `CHK({analog_digital_q, analog_mux_q}, {2{analog_input_port}})
            `CHK(serial_rx_line_q, drv_val[16])
            `CHK({ext_irq_b_q, ext_irq_a_q}, drv_val[19:18])
            `CHK({count_in_b_q, count_in_a_q}, drv_val[21:20])
            `CHK(irq_capcomp_q, drv_val[3:0])
            `CHK({reload_trigger_in_q, ext_irq_c_q}, drv_val[5:4])
            `CHK(count_in_c_q, drv_val[7])
            `CHK(verify_addr_q, {drv_val[7], 1'b1, drv_val[5:0]})
            `CHK(timer_alt_rd_q, {drv_val[7], 1'b1, drv_val[5:0]})
            `CHK(control_alt_rd_q, drv_val[23:16] | 8'hC2)
            `CHK({high_address_rd_q, aux_io_rd_q}, {hv, av})
        end
        verify_mode = 0; drv_en = '0; compare_en = 4'hF;
        compare_val = 4'($urandom); ext_write_strobe_n = 0; serial_tx_bit = 0;
        step(2); `CHK(timer_alt_out[3:0], compare_val)
        `CHK(timer_alt_oe[3:0], 4'hF)
        `CHK({control_alt_out[7:6], control_alt_out[1]}, 3'b100)
        `CHK({control_alt_oe[7:6], control_alt_oe[1]}, 3'b011)
        ext_write_strobe_n = 1; ext_read_strobe_n = 0; step(2);
        `CHK(control_alt_out[7:6], 2'b01)
        ext_read_strobe_n = 1; compare_en = 0; serial_tx_bit = 1;
        for (int m = 0; m < 4; m++) begin
            bus_mode = m[1:0]; addr_high = 8'($urandom); step(2);
            `CHK({high_address_out, high_address_oe},
                m[0] ? {addr_high, 8'hFF} : {hv, ~hv})
        end
        bus_mode = 0; sys_clock_out_en = 1; step(20);
        `CHK(timer_alt_oe[TA_CLK], 1'b1)
        for (int j = 0; j < 2; j++) begin
            t = timer_alt_out[TA_CLK]; n = 0;
            while (timer_alt_out[TA_CLK] === t && n < 20) begin
                step(1); n++;
            end
        end
        `CHK(n, 6)
        sys_clock_out_en = 0; idle_req = 1; step(8); `CHK(idle_q, 1'b0)
        power_save_allow = 0; step(5); `CHK(idle_q, 1'b1)
        idle_req = 0; pdown_req = 1; step(5); `CHK(pdown_q, 1'b1)
        pdown_req = 0; power_save_allow = 1; reset_pin_n = 0; step(22);
        `CHK(chip_reset_q, 1'b0)
        step(8); `CHK({chip_reset_q, idle_q, pdown_q}, 3'b100)
        reset_pin_n = 1; step(4); `CHK(chip_reset_q, 1'b0)
        pdown_req = 1; step(8); `CHK(pdown_q, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
